//--- tb.sv
// Self-checking testbench for the capture/reload timer block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmrc_pkg::*;

    // =====================================================================
    // Signals
    // =====================================================================
    logic        hclk = 1'b0;  // 200 MHz bus clock
    logic        hresetn;      // Active-low reset
    logic        hsel;         // Slave select
    logic [31:0] haddr;        // Byte address
    logic [1:0]  htrans;       // Transfer type
    logic        hwrite;       // Direction
    logic [2:0]  hsize;        // Always word
    logic [31:0] hwdata;       // Write data
    logic [31:0] hrdata;       // Read data
    logic        hreadyout;    // Doubles as bus hready
    logic        hresp;        // Always OKAY
    logic        cnt_pin;      // Count pin from model
    logic        trg_pin;      // Trigger pin from model
    logic        t1_ovf;       // Timer1 overflow from model
    logic        idle_mode;    // Processor idle
    logic [1:0]  uart_mode;    // UART mode
    logic        rx_baud_tick; // Receive baud pulse
    logic        tx_baud_tick; // Transmit baud pulse
    logic        irq;          // Interrupt request
    logic [31:0] rx_n = '0;    // Receive ticks seen
    logic [31:0] tx_n = '0;    // Transmit ticks seen
    int          fail_count = 0;
    int          checks = 0;

    always #2.5 hclk = ~hclk;

    tmrc_timer i_tmrc_timer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
        .idle_mode(idle_mode), .uart_mode(uart_mode),
        .timer1_overflow(t1_ovf), .rx_baud_tick(rx_baud_tick),
        .tx_baud_tick(tx_baud_tick), .irq(irq));

    tmrc_pins_model i_tmrc_pins_model (
        .hclk(hclk), .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
        .timer1_overflow(t1_ovf));

    // One-cycle pulses are counted on every edge so none is missed
    always @(posedge hclk) begin
        if (rx_baud_tick === 1'b1) rx_n <= rx_n + 1;
        if (tx_baud_tick === 1'b1) tx_n <= tx_n + 1;
    end

    // =====================================================================
    // Reporting
    // =====================================================================
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // =====================================================================
    // Bus tasks
    // =====================================================================
    // Bounded wait for hready at a rising edge; a hang ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                final_report();
            end
            @(posedge hclk);
        end
    endtask

    task automatic xfer(logic [7:0] idx, logic wr, logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(logic [7:0] idx, logic [7:0] d);
        logic [31:0] rd;
        xfer(idx, 1'b1, {24'h000000, d}, rd);
    endtask

    task automatic rdc(logic [7:0] idx, logic [7:0] exp);
        logic [31:0] rd;
        xfer(idx, 1'b0, 32'h00000000, rd);
        chk($sformatf("reg %h", idx), rd, {24'h000000, exp});
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    localparam logic [7:0] IDXS [9] = '{IDX_TIMER_CONTROL, IDX_RC_LOW,
        IDX_RC_HIGH, IDX_COUNT_LOW, IDX_COUNT_HIGH, IDX_IRQ_CONTROL,
        IDX_IRQ_STATUS, IDX_IRQ_MASK, 8'h10};

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'h2; hwdata = '0;
        idle_mode = 1'b0; uart_mode = 2'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values, the last index being unmapped
        foreach (IDXS[i]) rdc(IDXS[i], 8'h00);
        wr(IDX_RC_LOW, 8'hA5); wr(IDX_RC_HIGH, 8'h5A);
        wr(IDX_COUNT_LOW, 8'h3C); wr(IDX_COUNT_HIGH, 8'hC3);
        rdc(IDX_RC_LOW, 8'hA5); rdc(IDX_RC_HIGH, 8'h5A);
        rdc(IDX_COUNT_LOW, 8'h3C); rdc(IDX_COUNT_HIGH, 8'hC3);
        // Twenty running clocks give ten counts, then the count holds
        wr(IDX_COUNT_LOW, 8'h00); wr(IDX_COUNT_HIGH, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h04);
        repeat (18) @(posedge hclk);
        wr(IDX_TIMER_CONTROL, 8'h00);
        repeat (10) @(posedge hclk);
        rdc(IDX_COUNT_LOW, 8'h0A);
        // Idle with clock stop freezes the count
        wr(IDX_IRQ_CONTROL, 8'h04); idle_mode <= 1'b1;
        wr(IDX_TIMER_CONTROL, 8'h04);
        repeat (20) @(posedge hclk);
        wr(IDX_TIMER_CONTROL, 8'h00);
        rdc(IDX_COUNT_LOW, 8'h0A);
        idle_mode <= 1'b0; wr(IDX_IRQ_CONTROL, 8'h00);
        // Wrap reloads from the pair and raises the overflow flag
        wr(IDX_RC_LOW, 8'h34); wr(IDX_RC_HIGH, 8'h12);
        wr(IDX_COUNT_LOW, 8'hFF); wr(IDX_COUNT_HIGH, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h04);
        repeat (4) @(posedge hclk);
        rdc(IDX_COUNT_HIGH, 8'h12);
        rdc(IDX_TIMER_CONTROL, 8'h84);
        rdc(IDX_IRQ_STATUS, 8'h01);
        // Request needs timer and global enables
        wr(IDX_IRQ_MASK, 8'h03); wr(IDX_IRQ_CONTROL, 8'h01);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(IDX_IRQ_CONTROL, 8'h03);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rdc(IDX_IRQ_STATUS, 8'h00);
        // Counter mode, then capture on a trigger fall
        wr(IDX_TIMER_CONTROL, 8'h00);
        wr(IDX_COUNT_LOW, 8'h78); wr(IDX_COUNT_HIGH, 8'h56);
        wr(IDX_TIMER_CONTROL, 8'h0F);
        repeat (3) i_tmrc_pins_model.fall_count();
        i_tmrc_pins_model.fall_trig();
        rdc(IDX_RC_LOW, 8'h7B);
        rdc(IDX_RC_HIGH, 8'h56);
        rdc(IDX_TIMER_CONTROL, 8'h4F);
        chk("irq", {31'h0, irq}, 32'h1);
        rdc(IDX_IRQ_STATUS, 8'h02);
        // Trigger ignored while its enable is off
        wr(IDX_TIMER_CONTROL, 8'h07); wr(IDX_IRQ_STATUS, 8'h02);
        // New count so a wrongful capture would show in the pair
        wr(IDX_COUNT_LOW, 8'h11);
        i_tmrc_pins_model.fall_trig();
        rdc(IDX_TIMER_CONTROL, 8'h07);
        rdc(IDX_RC_LOW, 8'h7B);
        // Trigger reload in reload mode
        wr(IDX_RC_LOW, 8'hAB); wr(IDX_RC_HIGH, 8'h00);
        wr(IDX_TIMER_CONTROL, 8'h0E);
        i_tmrc_pins_model.fall_trig();
        rdc(IDX_COUNT_LOW, 8'hAB); rdc(IDX_COUNT_HIGH, 8'h00);
        rdc(IDX_TIMER_CONTROL, 8'h4E);
        // Baud use: capture bit ignored, no flag, ticks routed by select
        wr(IDX_TIMER_CONTROL, 8'h00); uart_mode <= 2'h1;
        wr(IDX_RC_LOW, 8'h00); wr(IDX_RC_HIGH, 8'hFF);
        wr(IDX_COUNT_LOW, 8'hFF); wr(IDX_COUNT_HIGH, 8'hFF);
        wr(IDX_TIMER_CONTROL, 8'h15);
        repeat (6) @(posedge hclk);
        rdc(IDX_TIMER_CONTROL, 8'h15);
        wr(IDX_TIMER_CONTROL, 8'h10);
        i_tmrc_pins_model.pulse_t1();
        rdc(IDX_COUNT_HIGH, 8'hFF);
        chk("rx ticks", rx_n, 32'h1);
        chk("tx ticks", tx_n, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire

//--- tmrc_pins_model.sv
// Behavioural model of the count pin, trigger pin and timer1 overflow
`default_nettype none
module tmrc_pins_model (
    input  wire logic hclk,
    output logic      count_input_pin,
    output logic      trigger_pin,
    output logic      timer1_overflow
);
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // Idle levels
    // =====================================================================
    // Both pins rest high, as a pull-up would leave them
    initial begin
        count_input_pin = 1'b1;
        trigger_pin     = 1'b1;
        timer1_overflow = 1'b0;
    end

    // =====================================================================
    // Pin activity
    // =====================================================================
    // Held low eight clocks so the synchroniser agrees on the level
    task automatic fall_count();
        @(posedge hclk);
        count_input_pin <= 1'b0;
        repeat (8) @(posedge hclk);
        count_input_pin <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask

    // Same shape on the trigger pin; the long high gap lets effects land
    task automatic fall_trig();
        @(posedge hclk);
        trigger_pin <= 1'b0;
        repeat (8) @(posedge hclk);
        trigger_pin <= 1'b1;
        repeat (8) @(posedge hclk);
    endtask

    // Timer1 overflow is a single-cycle pulse
    task automatic pulse_t1();
        @(posedge hclk);
        timer1_overflow <= 1'b1;
        @(posedge hclk);
        timer1_overflow <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

//--- tmrc_pkg.sv
// Package of constants and types for the capture/reload timer block
`default_nettype none
package tmrc_pkg;

    // =====================================================================
    // Register indices (byte address is four times the index)
    // =====================================================================
    localparam logic [7:0] IDX_TIMER_CONTROL = 8'hC8; // Mode and flags
    localparam logic [7:0] IDX_RC_LOW        = 8'hCA; // Reload/capture low
    localparam logic [7:0] IDX_RC_HIGH       = 8'hCB; // Reload/capture high
    localparam logic [7:0] IDX_COUNT_LOW     = 8'hCC; // Running count low
    localparam logic [7:0] IDX_COUNT_HIGH    = 8'hCD; // Running count high
    localparam logic [7:0] IDX_IRQ_CONTROL   = 8'hE0; // Enables, clock stop
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'hE1; // Sticky events, W1C
    localparam logic [7:0] IDX_IRQ_MASK      = 8'hE2; // Event mask

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int IRQC_TIMER_EN_BIT  = 0; // Timer interrupt enable
    localparam int IRQC_GLOBAL_EN_BIT = 1; // Global interrupt enable
    localparam int IRQC_IDLE_STOP_BIT = 2; // Stop timer clock in idle
    localparam int STS_OVF_BIT        = 0; // Overflow event
    localparam int STS_EDGE_BIT       = 1; // Trigger edge event

    // =====================================================================
    // Reset values and counts
    // =====================================================================
    localparam logic [7:0]  RST_BYTE     = 8'h00; // Timer control byte
    localparam logic [15:0] RST_WORD     = 16'h0000; // Count and reload
    localparam logic [1:0]  RST_STS      = 2'h0; // Status and mask
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF; // Wraps after this
    localparam int          PRESCALE_DIV = 2; // System clocks per tick

    // =====================================================================
    // Types
    // =====================================================================
    // Timer control byte, bit 7 first
    typedef struct packed {
        logic overflow_flag;         // Sticky overflow
        logic ext_edge_flag;         // Sticky trigger edge
        logic rx_baud_select;        // Receive baud from this timer
        logic tx_baud_select;        // Transmit baud from this timer
        logic trigger_pin_enable;    // Trigger pin acts
        logic run_control;           // Counting allowed
        logic counter_select;        // 1: count pin edges
        logic capture_reload_select; // 1: capture mode
    } tmrc_ctrl_s;

    // Interrupt control fields
    typedef struct packed {
        logic idle_periph_clock_stop; // Freeze in idle
        logic global_irq_enable;      // Global gate
        logic timer_irq_enable;       // Timer gate
    } tmrc_irqc_s;

endpackage
`default_nettype wire

//--- tmrc_sync_fall.sv
// Three-stage pin synchroniser with agreed falling-edge detection
`default_nettype none
module tmrc_sync_fall #(
    parameter logic IDLE_LEVEL = 1'b1 // Pin level assumed after reset
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_in,
    output logic      fall_pulse
);

    logic s1_q;    // First stage, read only by s2
    logic s2_q;    // Second stage
    logic s3_q;    // Third stage
    logic level_q; // Accepted pin level
    logic agree;   // Second and third stage match

    // A change counts only once two stages agree, filtering a lone glitch
    assign agree = (s2_q == s3_q);

    // =====================================================================
    // Synchroniser chain and accepted level
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q       <= IDLE_LEVEL;
            s2_q       <= IDLE_LEVEL;
            s3_q       <= IDLE_LEVEL;
            level_q    <= IDLE_LEVEL;
            fall_pulse <= 1'b0;
        end else begin
            s1_q       <= pin_in;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            level_q    <= agree ? s3_q : level_q;
            fall_pulse <= agree & level_q & ~s3_q;
        end
    end

endmodule
`default_nettype wire

//--- tmrc_timer.sv
// Capture/reload timer with AHB-Lite register slave and interrupt logic
`default_nettype none
module tmrc_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        count_input_pin,
    input  wire logic        trigger_pin,
    input  wire logic        idle_mode,
    input  wire logic [1:0]  uart_mode,
    input  wire logic        timer1_overflow,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             irq
);
    import tmrc_pkg::*;

    // =====================================================================
    // State
    // =====================================================================
    tmrc_ctrl_s  ctrl_q;    // Timer control byte
    tmrc_irqc_s  irqc_q;    // Interrupt control
    logic [15:0] count_q;   // Running count
    logic [15:0] rc_q;      // Reload/capture pair
    logic [1:0]  sts_q;     // Sticky event status
    logic [1:0]  mask_q;    // Event mask
    logic        pre_q;     // Divide-by-two phase
    logic        wr_pend_q; // Write data phase pending
    logic        rd_pend_q; // Read wait state pending
    logic [31:0] addr_q;    // Captured address

    // =====================================================================
    // Bus decode
    // =====================================================================
    // Register hit test on a word-aligned byte address
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [7:0]  idx);
        reg_hit = (a == {22'h0, idx, 2'h0});
    endfunction

    logic addr_take; // Valid address phase
    logic wr_go;     // Write applied this cycle
    logic [7:0] wb;  // Write byte
    assign addr_take = hsel & hready & htrans[1];
    assign wr_go     = wr_pend_q;
    assign wb        = hwdata[7:0];

    logic w_ctrl, w_rcl, w_rch, w_cl, w_ch, w_irqc, w_sts, w_mask;
    assign w_ctrl = wr_go & reg_hit(addr_q, IDX_TIMER_CONTROL);
    assign w_rcl  = wr_go & reg_hit(addr_q, IDX_RC_LOW);
    assign w_rch  = wr_go & reg_hit(addr_q, IDX_RC_HIGH);
    assign w_cl   = wr_go & reg_hit(addr_q, IDX_COUNT_LOW);
    assign w_ch   = wr_go & reg_hit(addr_q, IDX_COUNT_HIGH);
    assign w_irqc = wr_go & reg_hit(addr_q, IDX_IRQ_CONTROL);
    assign w_sts  = wr_go & reg_hit(addr_q, IDX_IRQ_STATUS);
    assign w_mask = wr_go & reg_hit(addr_q, IDX_IRQ_MASK);

    // =====================================================================
    // Pin edges
    // =====================================================================
    logic cnt_fall;  // Agreed fall on count pin
    logic trig_fall; // Agreed fall on trigger pin

    tmrc_sync_fall #(.IDLE_LEVEL(1'b1)) u_cnt_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (count_input_pin),
        .fall_pulse (cnt_fall)
    );

    tmrc_sync_fall #(.IDLE_LEVEL(1'b1)) u_trig_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .pin_in     (trigger_pin),
        .fall_pulse (trig_fall)
    );

    // =====================================================================
    // Counting events
    // =====================================================================
    logic stopped;     // Clock to timer held in idle
    logic running;     // Allowed to advance
    logic inc_evt;     // One count step
    logic wrap;        // Count passes its maximum
    logic baud;        // Either baud select set
    logic trig_evt;    // Trigger edge that acts
    logic reload_evt;  // Reload this cycle
    logic capture_evt; // Capture this cycle

    // Stopping means nothing advances: the prescale phase freezes too
    assign stopped  = irqc_q.idle_periph_clock_stop & idle_mode;
    assign running  = ctrl_q.run_control & ~stopped;
    assign inc_evt  = running & (ctrl_q.counter_select ?
                                 cnt_fall :
                                 pre_q);
    assign wrap     = inc_evt & (count_q == COUNT_MAX);
    assign baud     = ctrl_q.rx_baud_select | ctrl_q.tx_baud_select;
    // Pin ignored unless enabled and no baud select
    assign trig_evt = trig_fall & ctrl_q.trigger_pin_enable & ~baud;
    // Baud use forces reload whatever the mode bit says
    assign reload_evt = (wrap & (baud |
                                 ~ctrl_q.capture_reload_select)) |
                        (trig_evt & ~ctrl_q.capture_reload_select);
    assign capture_evt = trig_evt & ctrl_q.capture_reload_select;

    // =====================================================================
    // Next values
    // =====================================================================
    logic [15:0] count_hw; // Count after hardware action
    logic [15:0] count_d;  // Count after byte writes
    logic [15:0] rc_hw;    // Pair after capture
    logic [15:0] rc_d;     // Pair after byte writes
    tmrc_ctrl_s  ctrl_d;   // Control next
    logic        ovf_set;  // Overflow flag set
    logic [1:0]  sts_set;  // Status set terms
    logic [1:0]  sts_d;    // Status next

    // Reload shows in the count one cycle after its event
    assign count_hw = reload_evt ? rc_q :
                      inc_evt    ? count_q + 16'h0001 : count_q;
    // Software byte writes win over counting in the same cycle
    assign count_d  = {w_ch ? wb : count_hw[15:8],
                       w_cl ? wb : count_hw[7:0]};
    assign rc_hw    = capture_evt ? count_q : rc_q;
    assign rc_d     = {w_rch ? wb : rc_hw[15:8],
                       w_rcl ? wb : rc_hw[7:0]};

    assign ovf_set = wrap & ~baud;
    // Flag set beats a software clear in the same cycle
    always_comb begin
        ctrl_d = w_ctrl ? tmrc_ctrl_s'(wb) : ctrl_q;
        ctrl_d.overflow_flag = ctrl_d.overflow_flag | ovf_set;
        ctrl_d.ext_edge_flag = ctrl_d.ext_edge_flag | trig_evt;
    end

    assign sts_set = {trig_evt, ovf_set};
    assign sts_d   = sts_set | (sts_q & ~(w_sts ? wb[1:0] : 2'h0));

    // =====================================================================
    // Read mux
    // =====================================================================
    logic [7:0] rd_byte; // Selected register
    assign rd_byte =
        reg_hit(addr_q, IDX_TIMER_CONTROL) ? ctrl_q          :
        reg_hit(addr_q, IDX_RC_LOW)        ? rc_q[7:0]       :
        reg_hit(addr_q, IDX_RC_HIGH)       ? rc_q[15:8]      :
        reg_hit(addr_q, IDX_COUNT_LOW)     ? count_q[7:0]    :
        reg_hit(addr_q, IDX_COUNT_HIGH)    ? count_q[15:8]   :
        reg_hit(addr_q, IDX_IRQ_CONTROL)   ? {5'h00, irqc_q} :
        reg_hit(addr_q, IDX_IRQ_STATUS)    ? {6'h00, sts_q}  :
        reg_hit(addr_q, IDX_IRQ_MASK)      ? {6'h00, mask_q} :
                                             8'h00; // Unmapped

    // =====================================================================
    // Interrupt and baud terms
    // =====================================================================
    logic req;      // Masked event request
    logic irq_d;    // Gated request
    logic variable; // UART mode 1 or 3
    assign req      = |(sts_q & mask_q);
    assign irq_d    = req & irqc_q.timer_irq_enable &
                      irqc_q.global_irq_enable;
    assign variable = uart_mode[0];
    // The timer's tick is its wrap, with or without the flag being set

    // =====================================================================
    // Bus slave state: writes no wait, reads one wait state
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= addr_take & hwrite;
            rd_pend_q <= addr_take & ~hwrite;
            addr_q    <= addr_take ? haddr : addr_q;
            hreadyout <= ~(addr_take & ~hwrite);
            hrdata    <= rd_pend_q ? {24'h000000, rd_byte} : hrdata;
            hresp     <= 1'b0;
        end
    end

    // =====================================================================
    // Timer registers
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= tmrc_ctrl_s'(RST_BYTE);
            count_q <= RST_WORD;
            rc_q    <= RST_WORD;
            pre_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            count_q <= count_d;
            rc_q    <= rc_d;
            pre_q   <= running ? ~pre_q : pre_q;
        end
    end

    // =====================================================================
    // Interrupt registers and outputs
    // =====================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irqc_q       <= tmrc_irqc_s'(3'h0);
            sts_q        <= RST_STS;
            mask_q       <= RST_STS;
            irq          <= 1'b0;
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            irqc_q       <= w_irqc ? tmrc_irqc_s'(wb[2:0]) : irqc_q;
            sts_q        <= sts_d;
            mask_q       <= w_mask ? wb[1:0] : mask_q;
            irq          <= irq_d;
            rx_baud_tick <= variable & (ctrl_q.rx_baud_select ?
                                        wrap : timer1_overflow);
            tx_baud_tick <= variable & (ctrl_q.tx_baud_select ?
                                        wrap : timer1_overflow);
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    property p_ovf_flag;
        @(posedge hclk) disable iff (!hresetn)
        (wrap && !baud) |=> ctrl_q.overflow_flag;
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set");

    property p_baud_no_flag;
        @(posedge hclk) disable iff (!hresetn)
        (baud && !ctrl_q.overflow_flag && !w_ctrl) |=>
            !ctrl_q.overflow_flag;
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag)
        else $error("overflow flag set in baud use");

    property p_edge_flag;
        @(posedge hclk) disable iff (!hresetn)
        trig_evt |=> ctrl_q.ext_edge_flag && sts_q[STS_EDGE_BIT];
    endproperty
    a_edge_flag: assert property (p_edge_flag)
        else $error("edge flag not set");

    property p_pin_ignored;
        @(posedge hclk) disable iff (!hresetn)
        (trig_fall && (!ctrl_q.trigger_pin_enable || baud)) |->
            !reload_evt || wrap;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored)
        else $error("disabled trigger pin acted");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!ctrl_q.run_control && !w_cl && !w_ch && !reload_evt) |=>
            $stable(count_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved while stopped");

    property p_half_rate;
        @(posedge hclk) disable iff (!hresetn)
        (inc_evt && !ctrl_q.counter_select && !w_ctrl) |=> !inc_evt;
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("timer mode stepped twice in a row");

    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        (reload_evt && !w_cl && !w_ch) |=> count_q == $past(rc_q);
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload value not loaded");

    property p_capture;
        @(posedge hclk) disable iff (!hresetn)
        (capture_evt && !w_rcl && !w_rch) |=> rc_q == $past(count_q);
    endproperty
    a_capture: assert property (p_capture)
        else $error("count not captured");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        irq |-> $past(irqc_q.timer_irq_enable) &&
                $past(irqc_q.global_irq_enable) && $past(req);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while gated");

    property p_idle_freeze;
        @(posedge hclk) disable iff (!hresetn)
        (stopped && !w_cl && !w_ch && !reload_evt) |=> $stable(count_q);
    endproperty
    a_idle_freeze: assert property (p_idle_freeze)
        else $error("count moved in idle stop");

    property p_rx_tick;
        @(posedge hclk) disable iff (!hresetn)
        (variable && !ctrl_q.rx_baud_select && timer1_overflow) |=>
            rx_baud_tick;
    endproperty
    a_rx_tick: assert property (p_rx_tick)
        else $error("receive tick missing on timer1 overflow");

    property p_tx_tick;
        @(posedge hclk) disable iff (!hresetn)
        (variable && ctrl_q.tx_baud_select && wrap) |=> tx_baud_tick;
    endproperty
    a_tx_tick: assert property (p_tx_tick)
        else $error("transmit tick missing on timer wrap");

    property p_irq_on;
        @(posedge hclk) disable iff (!hresetn)
        (req && irqc_q.timer_irq_enable && irqc_q.global_irq_enable) |=>
            irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("enabled request did not raise interrupt");

endmodule
`default_nettype wire
